// [include/spdc_pkg.sv]
// Package for the pin direction control block: offsets, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package spdc_pkg;

  // Register byte offsets
  localparam logic [7:0] SPDC_FUNC_OFS = 8'h00;
  localparam logic [7:0] SPDC_DIR_OFS  = 8'h04;
  localparam logic [7:0] SPDC_DIN_OFS  = 8'h08;
  localparam logic [7:0] SPDC_DOUT_OFS = 8'h0C;
  localparam logic [7:0] SPDC_MODE_OFS = 8'h10;

  // Field layout: 12 pins, bits 11..0
  localparam int         SPDC_NPINS    = 12;
  localparam int         SPDC_SOMI_BIT = 11;
  localparam int         SPDC_SIMO_BIT = 10;
  localparam int         SPDC_CLK_BIT  = 9;
  localparam int         SPDC_ENA_BIT  = 8;
  localparam int         SPDC_CS_MSB   = 7;

  // Values after reset
  localparam logic [11:0] SPDC_PIN_RST = 12'h000;
  localparam logic        SPDC_MODE_RST = 1'b0;

  // AXI responses
  localparam logic [1:0] SPDC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SPDC_RESP_SLVERR = 2'b10;

  typedef enum logic {SPDC_IDLE, SPDC_RESP} spdc_bus_state_t;

endpackage

// [design/spdc_pad_ctrl.sv]
// Per-pin pad control: selects direction and drive value for 12 pins.
// Assumes the serial engine supplies its own output values per pin.
`timescale 1ns/1ps
module spdc_pad_ctrl
  import spdc_pkg::*;
(
  // Configuration
  input  wire logic [11:0] func_sel,
  input  wire logic [11:0] dir_bits,
  input  wire logic [11:0] dout_bits,
  input  wire logic        master_mode,
  // Serial engine side
  input  wire logic [11:0] serial_out,
  // Pad side
  output logic      [11:0] pad_out,
  output logic      [11:0] pad_oe
);

  logic [11:0] serial_dir_bits;

  // Serial-mode direction: master drives clock, slave-in and chip selects
  function automatic logic [11:0] serial_dir(input logic master);
    logic [11:0] d;
    d = 12'h000;
    if (master) begin
      d = 12'hFFF;
      d[SPDC_SOMI_BIT] = 1'b0;
      d[SPDC_ENA_BIT]  = 1'b0;
    end else begin
      d[SPDC_SOMI_BIT] = 1'b1;
      d[SPDC_ENA_BIT]  = 1'b1;
    end
    return d;
  endfunction

  // Mode-driven direction; a call result cannot be bit-selected directly
  assign serial_dir_bits = serial_dir(master_mode);

  // Mux direction and value per pin
  always_comb begin
    for (int i = 0; i < SPDC_NPINS; i++) begin
      if (func_sel[i]) begin
        pad_oe[i]  = serial_dir_bits[i];
        pad_out[i] = serial_out[i];
      end else begin
        pad_oe[i]  = dir_bits[i];
        pad_out[i] = dir_bits[i] & dout_bits[i];
      end
    end
  end

endmodule

// [design/spdc_top.sv]
// Pin direction control top: AXI4-Lite registers and pad muxing.
// Assumes pad inputs are asynchronous and are synchronised here.
//
// Contract
// - Upper direction bits read zero, ignore writes
// - Bit 11 sets slave-out pin direction
// - Bit 10 sets slave-in pin direction
// - Bit 9 sets serial clock pin direction
// - Bit 8 sets enable pin direction
// - Bits 7-0 set chip-select pin directions
// - Serial function pins follow master/slave mode
// - Reset clears every direction bit to input
// - Function bit 0 GPIO, 1 serial
// - Read-only input bits show pin levels
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module spdc_top
  import spdc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial engine
  input  wire logic [11:0] serial_out,
  // Pads: bits 11 slave-out, 10 slave-in, 9 clock, 8 enable, 7-0 selects
  input  wire logic [11:0] pad_in,
  output logic      [11:0] pad_out,
  output logic      [11:0] pad_oe,
  output logic      [11:0] pin_func_sel
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [11:0]     func_reg, func_next;
  logic [11:0]     dir_reg, dir_next;
  logic [11:0]     dout_reg, dout_next;
  logic            mode_reg, mode_next;
  logic [11:0]     sync1_reg, sync2_reg;
  logic [7:0]      awaddr_reg, awaddr_next;
  logic [31:0]     wdata_reg, wdata_next;
  logic [3:0]      wstrb_reg, wstrb_next;
  logic            aw_have_reg, aw_have_next;
  logic            w_have_reg, w_have_next;
  logic            bvalid_reg, bvalid_next;
  logic [1:0]      bresp_reg, bresp_next;
  logic            rvalid_reg, rvalid_next;
  logic [1:0]      rresp_reg, rresp_next;
  logic [31:0]     rdata_reg, rdata_next;
  logic            do_write;
  logic [11:0]     wval;

  // Byte-lane merge of a 12-bit field; upper bits are dropped
  function automatic logic [11:0] merge12(input logic [11:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    logic [11:0] r;
    r = old;
    if (s[0]) r[7:0]  = d[7:0];
    if (s[1]) r[11:8] = d[11:8];
    return r;
  endfunction

  function automatic logic known_addr(input logic [7:0] a);
    return a == SPDC_FUNC_OFS || a == SPDC_DIR_OFS || a == SPDC_DIN_OFS ||
           a == SPDC_DOUT_OFS || a == SPDC_MODE_OFS;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser; second stage alone feeds readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= SPDC_PIN_RST;
      sync2_reg <= SPDC_PIN_RST;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign do_write      = aw_have_reg && w_have_reg && !bvalid_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    func_next    = func_reg;
    dir_next     = dir_reg;
    dout_next    = dout_reg;
    mode_next    = mode_reg;
    wval         = 12'h000;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = known_addr(awaddr_reg) ? SPDC_RESP_OKAY
                                            : SPDC_RESP_SLVERR;
      case (awaddr_reg)
        SPDC_FUNC_OFS: func_next = merge12(func_reg, wdata_reg, wstrb_reg);
        SPDC_DIR_OFS: begin
          wval     = merge12(dir_reg, wdata_reg, wstrb_reg);
          dir_next = wval;
        end
        SPDC_DOUT_OFS: dout_next = merge12(dout_reg, wdata_reg, wstrb_reg);
        SPDC_MODE_OFS: begin
          if (wstrb_reg[0]) begin
            mode_next = wdata_reg[0];
          end
        end
        default: ;                                // Input readback is fixed
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SPDC_RESP_OKAY;
      func_reg    <= SPDC_PIN_RST;
      dir_reg     <= SPDC_PIN_RST;
      dout_reg    <= SPDC_PIN_RST;
      mode_reg    <= SPDC_MODE_RST;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      func_reg    <= func_next;
      dir_reg     <= dir_next;
      dout_reg    <= dout_next;
      mode_reg    <= mode_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle answer, registered data
  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = known_addr(s_axi_araddr) ? SPDC_RESP_OKAY
                                             : SPDC_RESP_SLVERR;
      case (s_axi_araddr)
        SPDC_FUNC_OFS: rdata_next = {20'h0_0000, func_reg};
        SPDC_DIR_OFS:  rdata_next = {20'h0_0000, dir_reg};
        SPDC_DIN_OFS:  rdata_next = {20'h0_0000, sync2_reg};
        SPDC_DOUT_OFS: rdata_next = {20'h0_0000, dout_reg};
        SPDC_MODE_OFS: rdata_next = {31'h0000_0000, mode_reg};
        default:       rdata_next = 32'h0000_0000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= SPDC_RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;
  assign pin_func_sel = func_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pad muxing; software keeps absent chip-select bits zero
  spdc_pad_ctrl u_pad (
    .func_sel    (func_reg),
    .dir_bits    (dir_reg),
    .dout_bits   (dout_reg),
    .master_mode (mode_reg),
    .serial_out  (serial_out),
    .pad_out     (pad_out),
    .pad_oe      (pad_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_gpio_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (func_reg == 12'h000) |-> (pad_oe == dir_reg))
    else $error("GPIO pad enable differs from direction");
  a_dir_reset: assert property (@(posedge aclk)
    !aresetn |=> (dir_reg == 12'h000))
    else $error("Direction not cleared by reset");
  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_reg |-> (rdata_reg[31:12] == 20'h0_0000))
    else $error("Upper read bits not zero");
  a_dir_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && awaddr_reg == SPDC_DIR_OFS && wstrb_reg == 4'hF)
      |=> (dir_reg == $past(wdata_reg[11:0])))
    else $error("Direction write not stored");
  a_serial_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    (func_reg[SPDC_CLK_BIT]) |-> (pad_oe[SPDC_CLK_BIT] == mode_reg))
    else $error("Serial clock direction ignores mode");
  a_slave_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (func_reg[SPDC_SOMI_BIT]) |-> (pad_oe[SPDC_SOMI_BIT] == !mode_reg))
    else $error("Slave-out direction wrong in serial mode");
  a_input_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == SPDC_DIN_OFS)
      |=> (rdata_reg[11:0] == $past(sync2_reg)))
    else $error("Input readback wrong");
  a_pad_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (!func_reg[0] && !dir_reg[0]) |-> (!pad_oe[0] && !pad_out[0]))
    else $error("Input pad not released");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("Write response missing");

  c_dir_write: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_reg == SPDC_DIR_OFS);
  c_din_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == SPDC_DIN_OFS);
  c_serial_master: cover property (@(posedge aclk) disable iff (!aresetn)
    func_reg != 12'h000 && mode_reg);
  c_gpio_output: cover property (@(posedge aclk) disable iff (!aresetn)
    func_reg == 12'h000 && dir_reg != 12'h000);

endmodule

// [testbench/testbench.sv]
// Self-checking bench for the pin direction control block.
// Assumes the spdc_pkg map and a single 10 MHz clock domain.
`timescale 1ns/1ps
module testbench
  import spdc_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [11:0] serial_out;
  logic [11:0] pad_in;
  logic [11:0] pad_out;
  logic [11:0] pad_oe;
  logic [11:0] func_q;
  logic [31:0] rd_d;
  logic [1:0]  rsp;
  logic [11:0] dv;
  int          n_mismatch;
  int          total_checks;

  spdc_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_out(serial_out),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pin_func_sel(func_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write; handshakes sampled at the falling edge, where they are settled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, done;
    done = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      done = bvalid;
      rsp  = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Read; data taken in the cycle before the rready handshake edge
  task rd(input logic [7:0] a);
    logic ar_t, done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      done = rvalid;
      rd_d = rdata;
      rsp  = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the roughly 120 cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end

  // Main sequence
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    serial_out = 12'h3C5;
    pad_in = 12'h000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SPDC_DIR_OFS);
    chk("dir reset", rd_d, 32'h0000_0000);
    chk("oe reset", pad_oe, 12'h000);
    // Walk one output bit across every pin, GPIO mode
    dv = 12'hA5A;
    wr(SPDC_DOUT_OFS, {20'h0_0000, dv});
    for (int i = 0; i < 12; i++) begin
      wr(SPDC_DIR_OFS, 32'h0000_0001 << i); // all eight selects exist
      chk("oe walk", pad_oe, 12'h001 << i);
      chk("out walk", pad_out, (12'h001 << i) & dv);
    end
    // Upper bits read zero even when written with ones
    wr(SPDC_DIR_OFS, 32'hFFFF_FFFF);
    chk("dir wr resp", rsp, SPDC_RESP_OKAY);
    rd(SPDC_DIR_OFS);
    chk("dir upper", rd_d, 32'h0000_0FFF);
    // Level readback sees pins while they are outputs
    pad_in <= 12'h5A3;
    repeat (4) @(posedge aclk);
    rd(SPDC_DIN_OFS);
    chk("din", rd_d, 32'h0000_05A3);
    // Serial function: direction follows master or slave mode
    wr(SPDC_FUNC_OFS, 32'h0000_0FFF);
    wr(SPDC_MODE_OFS, 32'h0000_0001);
    chk("oe master", pad_oe, 12'h6FF);
    chk("out serial", pad_out, 12'h3C5);
    rd(SPDC_MODE_OFS);
    chk("mode rd", rd_d, 32'h0000_0001);
    wr(SPDC_MODE_OFS, 32'h0000_0000);
    chk("oe slave", pad_oe, 12'h900);
    wr(SPDC_DIR_OFS, 32'h0000_0000);
    chk("oe dir ign", pad_oe, 12'h900);
    // Mixed: upper pins serial, selects GPIO outputs
    wr(SPDC_FUNC_OFS, 32'h0000_0F00);
    wr(SPDC_DIR_OFS, 32'h0000_00FF);
    chk("oe mixed", pad_oe, 12'h9FF);
    chk("out mixed", pad_out, 12'h35A);
    // Unmapped place: write refused, read returns zero
    wr(8'h40, 32'hFFFF_FFFF);
    chk("unm wr", rsp, SPDC_RESP_SLVERR);
    rd(8'h40);
    chk("unm rd", rd_d, 32'h0000_0000);
    chk("unm rresp", rsp, SPDC_RESP_SLVERR);
    rd(SPDC_DIR_OFS);
    chk("dir kept", rd_d, 32'h0000_00FF);
    chk("func sel", func_q, 12'hF00);
    // Reset in mid-run clears directions and releases every pad
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe rst2", pad_oe, 12'h000);
    chk("func rst2", func_q, 12'h000);
    rd(SPDC_DIR_OFS);
    chk("dir rst2", rd_d, 32'h0000_0000);
    end_of_test;
  end
endmodule
